//--- dss_consts.vh
`ifndef DSS_CONSTS_VH
`define DSS_CONSTS_VH
// register byte offsets
`define DSS_REG_STEP_COUNT 8'h00
`define DSS_REG_STEP_TIMER 8'h04
`define DSS_REG_PRESET_STEP 8'h08
`define DSS_REG_CURRENT_STEP 8'h0c
`define DSS_REG_CONTROL 8'h10
`define DSS_REG_STATUS 8'h14
`define DSS_REG_TIMEBASE 8'h18
`define DSS_REG_FIRST_CTR 8'h1c
`define DSS_REG_LAST_STEP 8'h20
`define DSS_REG_CPS_BASE 8'h40
`define DSS_REG_EVSEL_BASE 8'h80
`define DSS_REG_PATTERN_BASE 8'hc0
// control register fields
`define DSS_CTL_START 0
`define DSS_CTL_JOG 1
`define DSS_CTL_RESET 2
`define DSS_CTL_RUN 3
`define DSS_CTL_NONRET 4
`define DSS_CTL_EVENT_VAR 5
// event select fields
`define DSS_EV_EN 4
// reset values
`define DSS_PRESET_RST 16'h0001
`define DSS_TIMEBASE_RST 16'h0001
`define DSS_LAST_STEP_RST 16'h0010
`define DSS_FIRST_CTR_RST 8'h00
`define DSS_CTR_POOL 9'h100
// timing: one timer count is 10 ms at 200 MHz
`define DSS_TICK_MS 10
`define DSS_CLK_MHZ 200
`define DSS_TICK_CYCLES (`DSS_TICK_MS * 1000 * `DSS_CLK_MHZ)
`define DSS_SCAN_CYCLES 16
`define DSS_AXI_OKAY 2'b00
`define DSS_AXI_SLVERR 2'b10
`endif

//--- dss_divider.v
`timescale 1ns/10ps
// free-running divider giving a one-cycle pulse every DIV cycles
module dss_divider #(
   parameter integer DIV = 16
) (
   // clock and reset
   input wire CLK,
   input wire ARST_N,
   // pulse out
   output reg TICK
);
   reg [31:0] cnt_r;
   // count up and pulse on wrap
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt_r <= 32'h0;
         TICK <= 1'b0;
      end else if (cnt_r >= DIV - 1) begin
         cnt_r <= 32'h0;
         TICK <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
         TICK <= 1'b0;
      end
   end
endmodule

//--- dss_sequencer.v
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "dss_consts.vh"
// Overview of operation
// - with start on and reset off, timer runs and step events are watched
// - start off and reset off freezes step, timer and output pattern
// - event variant only: jog rising edge advances one step unless reset
// - reset overrides start and holds the preset step, no timing or events
// - preset step 1..16 is entered on reset and on non-retentive run-mode entry
// - each step has its own counts-per-step value
// - four consecutive status counters from a chosen first number of 256
// - each step has at most one selectable event input
// - outputs follow current step pattern in run mode, independent of start
// - non-retentive: run entry clears counts and timer, loads preset step
// - retentive: all four counters keep values across run-mode entry
// - retentive behaviour is the default configuration
// - after last step set done flag and keep last step number
// - reset clears done flag and forces the preset step
// - jog advance clears timer; timing continues at once if start is on
// - jog in last step moves the sequencer into the done state
// - dwell equals 10 ms times timebase times counts-per-step
// - with event and timer, timer counts only while event is true
// - entering a step switches outputs to that step pattern at once
// - sequencer logic evaluates once per scan
module dss_sequencer #(
   parameter integer TICK_CYCLES = `DSS_TICK_CYCLES
) (
   // clock and reset
   input wire CLK,
   input wire ARST_N,
   // axi4-lite write address and data
   input wire [7:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   // axi4-lite read
   input wire [7:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // discrete event points
   input wire [15:0] EVENT_IN,
   // step pattern and done flag
   output reg [15:0] PATTERN_OUT,
   output reg SEQUENCE_DONE_FLAG
);
   localparam ST_IDLE = 2'h0;
   localparam ST_RUN = 2'h1;
   localparam ST_DONE = 2'h2;
   reg [1:0] state_r;
   reg [15:0] step_count_r;
   reg [15:0] step_timer_r;
   reg [15:0] preset_r;
   reg [15:0] current_r;
   reg [5:0] ctl_r;
   reg [15:0] timebase_r;
   reg [7:0] first_ctr_r;
   reg [15:0] last_step_r;
   reg [15:0] cps_r [0:15];
   reg [4:0] evsel_r [0:15];
   reg [15:0] pat_r [0:15];
   reg [15:0] ev_s1_r;
   reg [15:0] ev_s2_r;
   reg tick_pend_r;
   reg jog_pend_r;
   reg jog_prev_r;
   reg run_prev_r;
   // scan strobe delayed one clock; the pattern follows the step chosen at the scan
   reg scan_d_r;
   reg aw_hold_r;
   reg w_hold_r;
   reg [7:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   wire tick;
   wire scan;
   integer i;
   // base timer count and scan strobe
   dss_divider #(.DIV(TICK_CYCLES)) u_tick (
      .CLK(CLK),
      .ARST_N(ARST_N),
      .TICK(tick)
   );
   dss_divider #(.DIV(`DSS_SCAN_CYCLES)) u_scan (
      .CLK(CLK),
      .ARST_N(ARST_N),
      .TICK(scan)
   );
   // event pins pass two flops
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ev_s1_r <= 16'h0;
         ev_s2_r <= 16'h0;
      end else begin
         ev_s1_r <= EVENT_IN;
         ev_s2_r <= ev_s1_r;
      end
   end
   // step-local views
   wire [3:0] cur_idx = current_r[3:0] - 4'h1;
   wire [4:0] cur_sel = evsel_r[cur_idx];
   wire ev_used = cur_sel[`DSS_EV_EN];
   wire ev_true = ev_s2_r[cur_sel[3:0]];
   wire [15:0] cur_cps = cps_r[cur_idx];
   wire run_mode = ctl_r[`DSS_CTL_RUN];
   wire run_entry = run_mode & ~run_prev_r;
   wire rst_in = ctl_r[`DSS_CTL_RESET];
   wire start_in = ctl_r[`DSS_CTL_START];
   wire at_last = (current_r >= last_step_r);
   wire [15:0] preset_ok = (preset_r == 16'h0 || preset_r > 16'h10) ? 16'h1 : preset_r;
   // axi handshakes
   assign S_AXI_AWREADY = ~aw_hold_r & ~S_AXI_BVALID;
   assign S_AXI_WREADY = ~w_hold_r & ~S_AXI_BVALID;
   assign S_AXI_ARREADY = ~S_AXI_RVALID;
   wire [7:0] wa = aw_hold_r ? awaddr_r : S_AXI_AWADDR;
   wire [31:0] wd = w_hold_r ? wdata_r : S_AXI_WDATA;
   wire [3:0] ws = w_hold_r ? wstrb_r : S_AXI_WSTRB;
   wire aw_ok = aw_hold_r | (S_AXI_AWVALID & S_AXI_AWREADY);
   wire w_ok = w_hold_r | (S_AXI_WVALID & S_AXI_WREADY);
   wire do_wr = aw_ok & w_ok;
   wire wr_tbl = (wa >= `DSS_REG_CPS_BASE);
   wire wr_known = wr_tbl || wa == `DSS_REG_PRESET_STEP || wa == `DSS_REG_CONTROL ||
      wa == `DSS_REG_TIMEBASE || wa == `DSS_REG_FIRST_CTR || wa == `DSS_REG_LAST_STEP;
   wire [15:0] wd16 = {ws[1] ? wd[15:8] : 8'h0, ws[0] ? wd[7:0] : 8'h0};
   wire wr_ctl = do_wr && wa == `DSS_REG_CONTROL && ws[0];
   wire wr_preset = do_wr && wa == `DSS_REG_PRESET_STEP && ws[0];
   // jog 0->1 written by software
   wire jog_set = wr_ctl && wd[`DSS_CTL_JOG] && !ctl_r[`DSS_CTL_JOG];
   // address and data capture, write response
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 8'h0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `DSS_AXI_OKAY;
      end else begin
         if (S_AXI_AWVALID & S_AXI_AWREADY) begin
            awaddr_r <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID & S_AXI_WREADY) begin
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
         end
         if (do_wr) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_known ? `DSS_AXI_OKAY : `DSS_AXI_SLVERR;
         end else begin
            aw_hold_r <= aw_ok;
            w_hold_r <= w_ok;
            if (S_AXI_BREADY) begin
               S_AXI_BVALID <= 1'b0;
            end
         end
      end
   end
   // configuration registers and step tables
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctl_r <= 6'h0;
         timebase_r <= `DSS_TIMEBASE_RST;
         first_ctr_r <= `DSS_FIRST_CTR_RST;
         last_step_r <= `DSS_LAST_STEP_RST;
         for (i = 0; i < 16; i = i + 1) begin
            cps_r[i] <= 16'h0;
            evsel_r[i] <= 5'h0;
            pat_r[i] <= 16'h0;
         end
      end else if (do_wr) begin
         if (wa == `DSS_REG_CONTROL && ws[0]) begin
            ctl_r <= wd[5:0];
         end
         if (wa == `DSS_REG_TIMEBASE) begin
            timebase_r <= wd16;
         end
         if (wa == `DSS_REG_FIRST_CTR && ws[0] && wd[7:0] <= 8'hfc) begin
            first_ctr_r <= wd[7:0];
         end
         if (wa == `DSS_REG_LAST_STEP && ws[0] && wd[4:0] >= 5'h1 && wd[4:0] <= 5'h10) begin
            last_step_r <= {11'h0, wd[4:0]};
         end
         if (wa >= `DSS_REG_CPS_BASE && wa < `DSS_REG_EVSEL_BASE) begin
            cps_r[wa[5:2]] <= wd16;
         end
         if (wa >= `DSS_REG_EVSEL_BASE && wa < `DSS_REG_PATTERN_BASE && ws[0]) begin
            evsel_r[wa[5:2]] <= wd[4:0];
         end
         if (wa >= `DSS_REG_PATTERN_BASE) begin
            pat_r[wa[5:2]] <= wd16;
         end
      end
   end
   // read channel
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= `DSS_AXI_OKAY;
      end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP <= `DSS_AXI_OKAY;
         if (S_AXI_ARADDR >= `DSS_REG_PATTERN_BASE) begin
            S_AXI_RDATA <= {16'h0, pat_r[S_AXI_ARADDR[5:2]]};
         end else if (S_AXI_ARADDR >= `DSS_REG_EVSEL_BASE) begin
            S_AXI_RDATA <= {27'h0, evsel_r[S_AXI_ARADDR[5:2]]};
         end else if (S_AXI_ARADDR >= `DSS_REG_CPS_BASE) begin
            S_AXI_RDATA <= {16'h0, cps_r[S_AXI_ARADDR[5:2]]};
         end else begin
            case (S_AXI_ARADDR)
               `DSS_REG_STEP_COUNT: S_AXI_RDATA <= {16'h0, step_count_r};
               `DSS_REG_STEP_TIMER: S_AXI_RDATA <= {16'h0, step_timer_r};
               `DSS_REG_PRESET_STEP: S_AXI_RDATA <= {16'h0, preset_r};
               `DSS_REG_CURRENT_STEP: S_AXI_RDATA <= {16'h0, current_r};
               `DSS_REG_CONTROL: S_AXI_RDATA <= {26'h0, ctl_r};
               `DSS_REG_STATUS: S_AXI_RDATA <= {29'h0, state_r, SEQUENCE_DONE_FLAG};
               `DSS_REG_TIMEBASE: S_AXI_RDATA <= {16'h0, timebase_r};
               `DSS_REG_FIRST_CTR: S_AXI_RDATA <= {24'h0, first_ctr_r};
               `DSS_REG_LAST_STEP: S_AXI_RDATA <= {16'h0, last_step_r};
               default: begin
                  S_AXI_RDATA <= 32'h0;
                  S_AXI_RRESP <= `DSS_AXI_SLVERR;
               end
            endcase
         end
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end
   // sequencer, stepped once per scan
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_r <= ST_IDLE;
         step_count_r <= 16'h0;
         step_timer_r <= 16'h0;
         preset_r <= `DSS_PRESET_RST;
         current_r <= `DSS_PRESET_RST;
         SEQUENCE_DONE_FLAG <= 1'b0;
         PATTERN_OUT <= 16'h0;
         tick_pend_r <= 1'b0;
         jog_pend_r <= 1'b0;
         jog_prev_r <= 1'b0;
         run_prev_r <= 1'b0;
         scan_d_r <= 1'b0;
      end else begin
         if (wr_preset) begin
            preset_r <= wd16;
         end
         // ticks between scans are remembered once
         if (tick) begin
            tick_pend_r <= 1'b1;
         end
         if (jog_set) begin
            jog_pend_r <= 1'b1; // set held until the scan consumes it
         end
         if (scan) begin
            run_prev_r <= run_mode;
            tick_pend_r <= 1'b0; // a tick on this edge is used below, not kept
            jog_pend_r <= jog_set; // a jog landing on the scan edge waits for the next
            jog_prev_r <= ctl_r[`DSS_CTL_JOG];
            if (!run_mode) begin
               state_r <= ST_IDLE;
            end else if (run_entry) begin
               state_r <= ST_RUN;
               if (ctl_r[`DSS_CTL_NONRET]) begin
                  step_count_r <= 16'h0;
                  step_timer_r <= 16'h0;
                  preset_r <= preset_ok;
                  current_r <= preset_ok;
                  SEQUENCE_DONE_FLAG <= 1'b0;
               end // retentive keeps all four
            end else if (rst_in) begin
               state_r <= ST_RUN;
               current_r <= preset_ok;
               step_count_r <= 16'h0;
               step_timer_r <= 16'h0;
               SEQUENCE_DONE_FLAG <= 1'b0;
            end else if (state_r == ST_RUN) begin
               if (ctl_r[`DSS_CTL_EVENT_VAR] && (jog_pend_r ||
                     (ctl_r[`DSS_CTL_JOG] && !jog_prev_r))) begin
                  step_count_r <= 16'h0;
                  step_timer_r <= 16'h0;
                  if (at_last) begin
                     state_r <= ST_DONE;
                     SEQUENCE_DONE_FLAG <= 1'b1;
                  end else begin
                     current_r <= current_r + 16'h1;
                  end
               end else if (start_in) begin
                  if (cur_cps == 16'h0 && ev_used) begin
                     if (ev_true) begin // event-only step
                        if (at_last) begin
                           state_r <= ST_DONE;
                           SEQUENCE_DONE_FLAG <= 1'b1;
                        end else begin
                           current_r <= current_r + 16'h1;
                        end
                     end
                  end else if (cur_cps == 16'h0 || step_count_r >= cur_cps) begin
                     step_count_r <= 16'h0;
                     step_timer_r <= 16'h0;
                     if (at_last) begin
                        state_r <= ST_DONE;
                        SEQUENCE_DONE_FLAG <= 1'b1;
                     end else begin
                        current_r <= current_r + 16'h1;
                     end
                  end else if ((tick_pend_r || tick) && (!ev_used || ev_true)) begin
                     if (step_timer_r + 16'h1 >= timebase_r) begin
                        step_timer_r <= 16'h0;
                        step_count_r <= step_count_r + 16'h1;
                     end else begin
                        step_timer_r <= step_timer_r + 16'h1;
                     end
                  end
               end
            end
         end
         // pattern of the step chosen at the last scan, also while reset or done;
         // one clock after the scan so a newly entered step shows at once
         scan_d_r <= scan;
         if (scan_d_r && run_mode) begin
            PATTERN_OUT <= pat_r[cur_idx];
         end
      end
   end
endmodule

//--- dss_seq_chk.sv
`timescale 1ns/10ps
// bus handshake and step output checks
module dss_seq_chk (
   // clock and reset
   input wire CLK,
   input wire ARST_N,
   // write channels
   input wire S_AXI_AWVALID,
   input wire S_AXI_AWREADY,
   input wire S_AXI_WVALID,
   input wire S_AXI_WREADY,
   input wire [1:0] S_AXI_BRESP,
   input wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   // read channels
   input wire S_AXI_ARVALID,
   input wire S_AXI_ARREADY,
   input wire [31:0] S_AXI_RDATA,
   input wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // step outputs
   input wire [15:0] PATTERN_OUT,
   input wire SEQUENCE_DONE_FLAG
);
   default clocking dcb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   // both write channels taken at one edge
   sequence s_wr_taken;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   // done flag rising
   sequence s_done_rise;
      !SEQUENCE_DONE_FLAG ##1 SEQUENCE_DONE_FLAG;
   endsequence
   chk_reset_outs: assert property (
      $rose(ARST_N) |-> PATTERN_OUT == 16'h0000 && !SEQUENCE_DONE_FLAG)
      else $error("outputs not clear after reset");
   chk_write_answer: assert property (
      s_wr_taken |=> S_AXI_BVALID) else $error("write response late");
   chk_bresp_hold: assert property (
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   chk_read_answer: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read data late");
   chk_rdata_hold: assert property (
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   chk_busy_refuse: assert property (
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write taken while busy");
   chk_scan_pattern: assert property (
      $changed(PATTERN_OUT) |=> $stable(PATTERN_OUT) [*8]) else $error("pattern off scan");
   chk_done_hold: assert property (
      s_done_rise |=> SEQUENCE_DONE_FLAG [*7]) else $error("done flag off scan");
   chk_done_pattern: assert property (
      SEQUENCE_DONE_FLAG |-> $stable(PATTERN_OUT)) else $error("pattern moved when done");
endmodule

bind dss_sequencer dss_seq_chk dss_seq_chk_i (.CLK(CLK), .ARST_N(ARST_N),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .PATTERN_OUT(PATTERN_OUT), .SEQUENCE_DONE_FLAG(SEQUENCE_DONE_FLAG));

//--- dss_ladder_model.sv
`timescale 1ns/10ps
// far-side logic: two contacts merged into one event relay
module dss_ladder_model (
   // clock
   input wire clk,
   // contacts from the bench
   input wire cond_a,
   input wire cond_b,
   // discrete points into the sequencer
   output reg [15:0] event_pts
);
   // relay on point 5; unselected points toggle so stale levels never help
   initial event_pts = 16'h5555;
   always @(posedge clk) begin
      event_pts <= ~event_pts;
      event_pts[5] <= cond_a & cond_b;
   end
endmodule

//--- tb_top.sv
`timescale 1ns/10ps
`include "dss_consts.vh"
// bench for the step sequencer
module tb_top;
   reg clk, arst_n = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   reg cond_a = 1'b0, cond_b = 1'b0;
   reg [7:0] awaddr = 8'h00, araddr = 8'h00, s;
   reg [31:0] wdata = 32'h0, rd;
   reg [1:0] rsp;
   wire awrdy, wrdy, bv, arrdy, rv, done;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] ev, pat;
   integer error_cnt = 0, compares = 0, cyc = 0, k;
   localparam [31:0] CR = 32'h28;
   dss_sequencer #(.TICK_CYCLES(4)) dss_sequencer_i (.CLK(clk), .ARST_N(arst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rready), .EVENT_IN(ev), .PATTERN_OUT(pat), .SEQUENCE_DONE_FLAG(done));
   dss_ladder_model dss_ladder_model_i (.clk(clk), .cond_a(cond_a), .cond_b(cond_b),
      .event_pts(ev));
   // clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         report_and_stop;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // one bus write, ready sampled settled at the falling edge
   task wr(input [7:0] a, input [31:0] d);
      reg ta, tw, tb;
      begin
         @(posedge clk);
         awaddr <= a;
         wdata <= d;
         awv <= 1'b1;
         wv <= 1'b1;
         bready <= 1'b1;
         do begin
            @(negedge clk);
            ta = awv & awrdy;
            tw = wv & wrdy;
            tb = bready & bv;
            if (tb) rsp = bresp;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) bready <= 1'b0;
         end while (awv | wv | bready);
      end
   endtask
   // one bus read
   task rdw(input [7:0] a);
      reg ta, tr;
      begin
         @(posedge clk);
         araddr <= a;
         arv <= 1'b1;
         rready <= 1'b1;
         do begin
            @(negedge clk);
            ta = arv & arrdy;
            tr = rready & rv;
            if (tr) rd = rdata;
            if (tr) rsp = rresp;
            @(posedge clk);
            if (ta) arv <= 1'b0;
            if (tr) rready <= 1'b0;
         end while (arv | rready);
      end
   endtask
   task rdc(input [7:0] a, input [31:0] exp);
      begin
         rdw(a);
         chk(rd, exp);
      end
   endtask
   // control write, then let a few scans pass
   task setc(input [31:0] v);
      begin
         wr(`DSS_REG_CONTROL, v);
         repeat (40) @(posedge clk);
         @(negedge clk); // outputs looked at settled
      end
   endtask
   task jog(input [31:0] v);
      begin
         setc(v | 32'h2);
         setc(v);
      end
   endtask
   task report_and_stop;
      begin
         $display("errors=%0d compares=%0d", error_cnt, compares);
         if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      // reset values and access kinds
      rdc(`DSS_REG_STEP_COUNT, 0);
      rdc(`DSS_REG_STEP_TIMER, 0);
      rdc(`DSS_REG_PRESET_STEP, 1);
      rdc(`DSS_REG_CURRENT_STEP, 1);
      rdc(`DSS_REG_CONTROL, 0);
      rdc(`DSS_REG_TIMEBASE, 1);
      rdc(`DSS_REG_LAST_STEP, 16);
      rdc(`DSS_REG_FIRST_CTR, 0);
      wr(`DSS_REG_FIRST_CTR, 32'hfc);
      rdc(`DSS_REG_FIRST_CTR, 32'hfc);
      wr(`DSS_REG_CURRENT_STEP, 5);
      rdc(`DSS_REG_CURRENT_STEP, 1);
      rdc(8'h24, 0);
      chk(rsp, `DSS_AXI_SLVERR);
      wr(8'h24, 1);
      chk(rsp, `DSS_AXI_SLVERR);
      // three steps, step 2 on event point 5 plus timer
      wr(`DSS_REG_LAST_STEP, 3);
      for (s = 8'h00; s < 8'h03; s = s + 8'h01) begin
         wr(`DSS_REG_PATTERN_BASE + 8'h04 * s, {24'h0, 8'h11 * (s + 8'h01)});
         wr(`DSS_REG_CPS_BASE + 8'h04 * s, 2);
      end
      wr(`DSS_REG_EVSEL_BASE + 8'h04, 32'h15);
      setc(CR);
      chk({16'h0, pat}, 32'h11);
      repeat (200) @(posedge clk);
      rdc(`DSS_REG_CURRENT_STEP, 1);
      jog(32'h08);
      rdc(`DSS_REG_CURRENT_STEP, 1);
      jog(CR);
      rdc(`DSS_REG_CURRENT_STEP, 2);
      rdc(`DSS_REG_STEP_TIMER, 0);
      chk({16'h0, pat}, 32'h22);
      // timer waits for the merged event
      setc(CR | 32'h1);
      repeat (300) @(posedge clk);
      rdc(`DSS_REG_CURRENT_STEP, 2);
      cond_a <= 1'b1;
      repeat (300) @(posedge clk);
      rdc(`DSS_REG_CURRENT_STEP, 2);
      cond_b <= 1'b1;
      for (k = 0; k < 3000 && done !== 1'b1; k = k + 1) @(negedge clk);
      chk(done, 1);
      rdc(`DSS_REG_CURRENT_STEP, 3);
      chk({16'h0, pat}, 32'h33);
      jog(CR | 32'h1);
      rdc(`DSS_REG_CURRENT_STEP, 3);
      // reset with start held, new preset
      wr(`DSS_REG_PRESET_STEP, 2);
      setc(CR | 32'h5);
      chk(done, 0);
      rdc(`DSS_REG_CURRENT_STEP, 2);
      chk({16'h0, pat}, 32'h22);
      repeat (300) @(posedge clk);
      rdc(`DSS_REG_CURRENT_STEP, 2);
      setc(CR);
      jog(CR);
      rdc(`DSS_REG_CURRENT_STEP, 3);
      jog(CR);
      chk(done, 1);
      // self-restart: the done flag ORed into reset
      setc(CR | {29'h0, done, 2'h0});
      chk(done, 0);
      rdc(`DSS_REG_CURRENT_STEP, 2);
      // run entry, non-retentive then retentive
      setc(32'h30);
      setc(32'h38);
      chk(done, 0);
      rdc(`DSS_REG_CURRENT_STEP, 2);
      rdc(`DSS_REG_STEP_COUNT, 0);
      rdc(`DSS_REG_STEP_TIMER, 0);
      jog(CR);
      setc(32'h20);
      setc(CR);
      rdc(`DSS_REG_CURRENT_STEP, 3);
      // all-off preset step seen at a non-retentive run entry
      wr(`DSS_REG_PATTERN_BASE + 8'h04, 0);
      setc(32'h30);
      setc(32'h38);
      chk({16'h0, pat}, 0);
      report_and_stop;
   end
endmodule
